/* logic/acbd_amp_control.sv */
// amplifier control bit decoder: control and volume registers, serial
// control-word receiver, turn-on sequencing and decoded amplifier controls.
// assumes serial pins and sense pins are asynchronous to clk_i and that
// an Avalon-MM master on clk_i reaches the registers.
`timescale 1ns/100ps

// Notes on behaviour
// - power-down bit 0 turns amplifier bias off; 1 allows normal operation.
// - all control bits clear on reset, so the part starts powered down.
// - volume-mode bit 0 forces fixed gain; 1 lets volume code set level.
// - silence bit 1 mutes speaker and dock outputs; 0 restores them.
// - alert tone detected above half supply enables the bridge outputs while the power-down bit is 1.
// - alert tone still reaches the bridge outputs while silenced.
// - headphone bit or headphone pin selects single-ended output mode.
// - headphone pin high wins over the headphone bit; with the pin low, the bit decides.
// - gain-source bit 0 uses internal gain, 1 uses external resistors.
// - amplifiers held at unity gain until bias reference settles.
// - five-bit volume code picks attenuation; all ones is 0 dB.
// - serial words are eight bits MSB first; extra clocks are ignored.
module acbd_amp_control
   import acbd_pkg::*;
#(
   parameter int SETTLE_CYCLES = TURN_ON_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // avalon-mm slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // serial control pins
   input wire logic ser_clk_i,
   input wire logic ser_data_i,
   input wire logic ser_enable_n_i,
   // sense pins
   input wire logic headphone_detect_pin_i,
   input wire logic alert_detect_i,
   // decoded amplifier controls
   output logic bias_on_o,
   output logic bridge_enable_o,
   output logic dock_enable_o,
   output logic single_ended_o,
   output logic gain_internal_o,
   output logic unity_gain_o,
   output logic [VOL_W-1:0] volume_code_o
);
   logic [CTRL_W-1:0] ctrl;
   logic [VOL_W-1:0] volume_code;
   logic ack;
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic ser_clk_d;
   logic [SER_BITS-1:0] ser_shift;
   logic [3:0] ser_count;
   logic ser_done;
   logic [SETTLE_W-1:0] settle_cnt;
   logic settled;
   logic next_ser_clk_rise;
   logic [SER_BITS-1:0] next_ser_word;
   logic bus_req;
   logic bus_wr;
   logic power_down_bit;
   logic silence_bit;
   logic volume_mode_bit;
   logic gain_source_bit;
   logic headphone_force_bit;
   logic ser_clk_s;
   logic ser_data_s;
   logic ser_enable_n_s;
   logic hp_pin_s;
   logic alert_s;
   logic hp_pin_1;
   logic hp_pin_2;
   logic alert_1;
   logic alert_2;

   assign power_down_bit = ctrl[POS_POWER_DOWN];
   assign silence_bit = ctrl[POS_SILENCE];
   assign volume_mode_bit = ctrl[POS_VOLUME_MODE];
   assign gain_source_bit = ctrl[POS_GAIN_SOURCE];
   assign headphone_force_bit = ctrl[POS_HEADPHONE_FORCE];
   assign ser_clk_s = sync2[0];
   assign ser_data_s = sync2[1];
   assign ser_enable_n_s = sync2[2];
   assign hp_pin_s = hp_pin_2;
   assign alert_s = alert_2;

   // two-stage synchronisers for every pin; the first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sync1 <= 3'h7;
         sync2 <= 3'h7;
         hp_pin_1 <= 1'b0;
         hp_pin_2 <= 1'b0;
         alert_1 <= 1'b0;
         alert_2 <= 1'b0;
      end else begin
         sync1 <= {ser_enable_n_i, ser_data_i, ser_clk_i};
         sync2 <= sync1;
         hp_pin_1 <= headphone_detect_pin_i;
         hp_pin_2 <= hp_pin_1;
         alert_1 <= alert_detect_i;
         alert_2 <= alert_1;
      end
   end

   // serial receiver: sampled on rising serial clock, MSB first
   assign next_ser_clk_rise = ser_clk_s & ~ser_clk_d;
   assign next_ser_word = {ser_shift[SER_BITS-2:0], ser_data_s};

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ser_clk_d <= 1'b1;
         ser_shift <= 8'h00;
         ser_count <= 4'h0;
         ser_done <= 1'b0;
      end else begin
         ser_clk_d <= ser_clk_s;
         ser_done <= 1'b0;
         if (ser_enable_n_s) begin
            // enable released early aborts a partial word
            ser_count <= 4'h0;
         end else if (next_ser_clk_rise && ser_count != SER_COUNT_FULL) begin
            // clocks past the eighth are ignored until enable releases
            ser_shift <= next_ser_word;
            ser_count <= ser_count + 4'h1;
            if (ser_count == SER_COUNT_FULL - 4'h1) begin
               ser_done <= 1'b1;
            end
         end
      end
   end

   ser_word_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ser_done |-> ser_count == SER_COUNT_FULL ##1 ser_count != 4'h9)
      else $error("serial word latched at wrong bit count");

   // a ninth clock inside one select must leave the latched word alone
   ser_extra_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !ser_enable_n_s && next_ser_clk_rise && ser_count == SER_COUNT_FULL
         |=> $stable(ser_shift) && !ser_done)
      else $error("serial clock past the eighth was used");

   ser_abort_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ser_enable_n_s |=> ser_count == 4'h0 && !ser_done)
      else $error("released select did not abort the word");

   // avalon slave: waitrequest drops for one cycle, one edge after the request
   // a write commits at the edge where the master sees waitrequest low, not before
   assign bus_req = (avs_read_i | avs_write_i) & ~ack;
   assign bus_wr = avs_write_i & ack;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ack <= 1'b0;
         avs_waitrequest_o <= 1'b1;
      end else begin
         ack <= bus_req;
         avs_waitrequest_o <= ~bus_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (bus_req && avs_read_i) begin
         unique case (avs_address_i)
            ADDR_CTRL: avs_readdata_o <= {27'h0, ctrl};
            ADDR_VOLUME: avs_readdata_o <= {27'h0, volume_code};
            ADDR_STATUS: avs_readdata_o <= {26'h0, bridge_enable_o, alert_s, hp_pin_s,
                                            single_ended_o, settled, bias_on_o};
            ADDR_SETTLE: avs_readdata_o <= {8'h0, settle_cnt};
            default: avs_readdata_o <= 32'h0000_0000;
         endcase
      end
   end

   wait_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");

   // read data is loaded at the accepting edge and must stand at the next one
   read_ctrl_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      bus_req && avs_read_i && avs_address_i == ADDR_CTRL
         |=> avs_readdata_o == {27'h0, $past(ctrl)})
      else $error("control read returned wrong data");

   read_volume_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      bus_req && avs_read_i && avs_address_i == ADDR_VOLUME
         |=> avs_readdata_o == {27'h0, $past(volume_code)})
      else $error("volume read returned wrong data");

   // control and volume registers; a serial word wins a same-cycle bus write
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ctrl <= CTRL_RESET;
         volume_code <= VOL_RESET;
      end else if (ser_done) begin
         if (ser_shift[POS_SER_SELECT]) begin
            volume_code <= ser_shift[VOL_W-1:0];
         end else begin
            ctrl <= ser_shift[CTRL_W-1:0];
         end
      end else if (bus_wr && avs_address_i == ADDR_CTRL) begin
         ctrl <= avs_writedata_i[CTRL_W-1:0];
      end else if (bus_wr && avs_address_i == ADDR_VOLUME) begin
         volume_code <= avs_writedata_i[VOL_W-1:0];
      end
   end

   ctrl_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !ser_done && !(bus_wr && avs_address_i == ADDR_CTRL) |=> $stable(ctrl))
      else $error("control bits changed without a write");

   vol_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !ser_done && !(bus_wr && avs_address_i == ADDR_VOLUME) |=> $stable(volume_code))
      else $error("volume code changed without a write");

   // serial words and bus writes to the control register must land exactly as sent
   ser_ctrl_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ser_done && !ser_shift[POS_SER_SELECT] |=> ctrl == CTRL_W'($past(ser_shift)))
      else $error("serial control word not applied");

   ser_volume_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ser_done && ser_shift[POS_SER_SELECT] |=> volume_code == VOL_W'($past(ser_shift)))
      else $error("serial volume word not applied");

   bus_ctrl_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !ser_done && bus_wr && avs_address_i == ADDR_CTRL
         |=> ctrl == CTRL_W'($past(avs_writedata_i)))
      else $error("bus write to control bits lost");

   reset_clear_a: assert property (@(posedge clk_i)
      sys_rst_i |=> ctrl == CTRL_RESET && !bias_on_o && !bridge_enable_o)
      else $error("control bits not clear after reset");

   // turn-on sequencing: counter restarts whenever the bias is switched off
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         settle_cnt <= '0;
         settled <= 1'b0;
      end else if (!power_down_bit) begin
         settle_cnt <= '0;
         settled <= 1'b0;
      end else if (!settled) begin
         settle_cnt <= settle_cnt + 1'b1;
         settled <= (settle_cnt == SETTLE_W'(SETTLE_CYCLES - 1));
      end
   end

   // the counter parks at its end value, so a long settle time cannot wrap
   settle_bound_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      settled || settle_cnt < SETTLE_W'(SETTLE_CYCLES))
      else $error("settle counter ran past its end");

   unity_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !settled |=> unity_gain_o)
      else $error("unity gain dropped before settling");

   // decoded controls, all registered one cycle after the control bits
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         bias_on_o <= 1'b0;
         bridge_enable_o <= 1'b0;
         dock_enable_o <= 1'b0;
         single_ended_o <= 1'b0;
         gain_internal_o <= 1'b1;
         unity_gain_o <= 1'b1;
         volume_code_o <= VOL_0DB;
      end else begin
         bias_on_o <= power_down_bit;
         // the alert tone drives the bridge even when silenced
         bridge_enable_o <= power_down_bit & (~silence_bit | alert_s);
         dock_enable_o <= power_down_bit & ~silence_bit;
         // pin high forces single-ended; pin low leaves the choice to the bit
         single_ended_o <= hp_pin_s | headphone_force_bit;
         gain_internal_o <= ~gain_source_bit;
         // power-down returns to unity at once, so the next turn-on starts quiet
         unity_gain_o <= ~(settled & power_down_bit);
         // fixed-gain mode bypasses the attenuator at 0 dB
         volume_code_o <= volume_mode_bit ? volume_code : VOL_0DB;
      end
   end

   shutdown_bias_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !power_down_bit |=> !bias_on_o && !bridge_enable_o && unity_gain_o)
      else $error("bias on while powered down");

   fixed_gain_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !volume_mode_bit |=> volume_code_o == VOL_0DB)
      else $error("volume code used in fixed-gain mode");

   volume_pass_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      volume_mode_bit |=> volume_code_o == $past(volume_code))
      else $error("volume code not passed in volume mode");

   silence_mute_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      silence_bit && !alert_s |=> !bridge_enable_o && !dock_enable_o)
      else $error("outputs live while silenced");

   alert_override_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      power_down_bit && alert_s |=> bridge_enable_o && (dock_enable_o == !$past(silence_bit)))
      else $error("alert tone blocked or dock unmuted");

   headphone_pin_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      hp_pin_s |=> single_ended_o)
      else $error("headphone pin did not force single-ended");

   headphone_bit_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !hp_pin_s |=> single_ended_o == $past(headphone_force_bit))
      else $error("single-ended mode does not follow bit");

   gain_source_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      gain_source_bit |=> !gain_internal_o)
      else $error("internal gain while external selected");

   turn_on_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(bias_on_o) |-> unity_gain_o [*8])
      else $error("unity gain released too early");

   settle_done_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !unity_gain_o |-> settle_cnt >= SETTLE_W'(SETTLE_CYCLES - 1))
      else $error("unity gain released before settle count");

   // decoded outputs track their bits one cycle later
   bias_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      power_down_bit |=> bias_on_o)
      else $error("bias off while power-down bit set");

   dock_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !power_down_bit |=> !dock_enable_o)
      else $error("dock output live while powered down");

   silence_open_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      power_down_bit && !silence_bit |=> bridge_enable_o && dock_enable_o)
      else $error("outputs stayed muted after silence cleared");

   gain_internal_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !gain_source_bit |=> gain_internal_o)
      else $error("external gain while internal selected");
endmodule

/* logic/acbd_pkg.sv */
// constants for the amplifier control bit decoder: register map,
// control-bit positions, reset values and turn-on timing.
// assumes a 50 MHz system clock and a byte-addressed Avalon-MM slave.
package acbd_pkg;
   // register byte addresses on the Avalon-MM slave
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_VOLUME = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_SETTLE = 4'hc;

   // control-bit positions in the control register
   localparam int POS_POWER_DOWN = 0;
   localparam int POS_SILENCE = 1;
   localparam int POS_VOLUME_MODE = 2;
   localparam int POS_GAIN_SOURCE = 3;
   localparam int POS_HEADPHONE_FORCE = 4;
   localparam int CTRL_W = 5;
   localparam int VOL_W = 5;

   // status-bit positions
   localparam int POS_ST_BIAS = 0;
   localparam int POS_ST_SETTLED = 1;
   localparam int POS_ST_SINGLE_ENDED = 2;
   localparam int POS_ST_HP_PIN = 3;
   localparam int POS_ST_ALERT = 4;
   localparam int POS_ST_BRIDGE = 5;

   // reset values: control and volume registers clear, so the part wakes in power-down
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
   localparam logic [VOL_W-1:0] VOL_RESET = 5'h00;
   localparam logic [VOL_W-1:0] VOL_0DB = 5'h1f;

   // serial control word: bit 7 selects target, low five bits carry data
   localparam int SER_BITS = 8;
   localparam int POS_SER_SELECT = 7;
   localparam logic [3:0] SER_COUNT_FULL = 4'h8;

   // turn-on time of the bias reference, in microseconds
   localparam int CLK_HZ = 50_000_000;
   localparam int TURN_ON_US = 2000;
   localparam int TURN_ON_CYCLES = TURN_ON_US * (CLK_HZ / 1_000_000);
   localparam int SETTLE_W = 24;
endpackage

/* verification/acbd_serial_host.sv */
// host controller model that writes control words on the serial pins.
// assumes clk_i is the system clock; each pin level is held pace cycles.
`timescale 1ns/100ps
module acbd_serial_host (
   // system clock
   input wire logic clk_i,
   // serial pins
   output logic ser_clk_o,
   output logic ser_data_o,
   output logic ser_enable_n_o
);
   // clock stands low outside frames, select idles high
   initial begin
      ser_clk_o = 1'b0;
      ser_data_o = 1'b0;
      ser_enable_n_o = 1'b1;
   end
   // pace of 3 or more keeps every level visible through the synchronisers
   task automatic send_word(input logic [7:0] word, input int nbits, input int pace);
      int i;
      @(posedge clk_i);
      ser_enable_n_o <= 1'b0;
      for (i = 0; i < nbits; i++) begin
         repeat (pace) @(posedge clk_i);
         ser_data_o <= word[7 - (i % 8)];
         repeat (pace) @(posedge clk_i);
         ser_clk_o <= 1'b1;
         repeat (pace) @(posedge clk_i);
         ser_clk_o <= 1'b0;
      end
      repeat (pace) @(posedge clk_i);
      ser_enable_n_o <= 1'b1;
      // released data line does not keep its last value
      ser_data_o <= ~ser_data_o;
   endtask
endmodule

/* verification/acbd_amp_control_bench.sv */
// self-checking bench for the amplifier control bit decoder.
// assumes the serial host model; the settle count is shortened to 16.
`timescale 1ns/100ps
module acbd_amp_control_bench
   import acbd_pkg::*;
;
   localparam int SETTLE = 16;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] v;
   logic wait_rq, sclk, sdat, sen_n, bias, bridge, dock, se, gint, unity;
   logic hp = 1'b0;
   logic alert = 1'b0;
   logic [VOL_W-1:0] vol;
   int fails = 0;
   int checked = 0;
   always #10 clk_i = ~clk_i;
   acbd_amp_control #(.SETTLE_CYCLES(SETTLE)) u_acbd_amp_control (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wait_rq), .ser_clk_i(sclk), .ser_data_i(sdat),
      .ser_enable_n_i(sen_n), .headphone_detect_pin_i(hp), .alert_detect_i(alert),
      .bias_on_o(bias), .bridge_enable_o(bridge), .dock_enable_o(dock),
      .single_ended_o(se), .gain_internal_o(gint), .unity_gain_o(unity),
      .volume_code_o(vol));
   acbd_serial_host u_acbd_serial_host (.clk_i(clk_i), .ser_clk_o(sclk),
      .ser_data_o(sdat), .ser_enable_n_o(sen_n));
   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task access(input logic [3:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_i);
      adr <= a;
      wr <= w;
      rd <= ~w;
      wdat <= d;
      // only the watchdog ends a wait that never finishes
      do begin
         @(posedge clk_i);
      end while (wait_rq !== 1'b0);
      v = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task wr_reg(input logic [3:0] a, input logic [31:0] d);
      access(a, 1'b1, d);
      repeat (2) @(posedge clk_i);
   endtask
   task rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
      access(a, 1'b0, 32'h0);
      check(v, exp, what);
   endtask
   // order: bias, bridge, dock, single-ended, internal gain, unity
   task outs(input logic [5:0] exp, input string what);
      check({26'h0, bias, bridge, dock, se, gint, unity}, {26'h0, exp}, what);
   endtask
   task test_done(input string name);
      $display("test %s done", name);
   endtask
   task complete_run;
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // the whole sequence needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      complete_run;
   end
   initial begin
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      outs(6'b000011, "reset outputs");
      check(vol, 5'h1f, "fixed volume");
      rd_chk(ADDR_CTRL, 32'h0, "ctrl reset");
      rd_chk(ADDR_VOLUME, 32'h0, "volume reset");
      test_done("reset");
      wr_reg(ADDR_CTRL, 32'h1);
      outs(6'b111011, "powered unity");
      repeat (SETTLE + 4) @(posedge clk_i);
      check(unity, 1'b0, "settled");
      wr_reg(ADDR_CTRL, 32'h3);
      outs(6'b100010, "muted");
      // host has left power-down before the tone arrives
      alert <= 1'b1;
      repeat (6) @(posedge clk_i);
      outs(6'b110010, "tone while muted");
      rd_chk(ADDR_STATUS, 32'h33, "status with tone");
      alert <= 1'b0;
      wr_reg(ADDR_CTRL, 32'h1);
      outs(6'b111010, "unmuted");
      test_done("power and mute");
      wr_reg(ADDR_VOLUME, 32'h0a);
      check(vol, 5'h1f, "fixed gain bypass");
      wr_reg(ADDR_CTRL, 32'h5);
      check(vol, 5'h0a, "volume mode");
      wr_reg(ADDR_VOLUME, 32'hff);
      rd_chk(ADDR_VOLUME, 32'h1f, "volume width");
      wr_reg(ADDR_CTRL, 32'h9);
      check(gint, 1'b0, "external gain");
      check(vol, 5'h1f, "fixed again");
      test_done("mode and gain");
      wr_reg(ADDR_CTRL, 32'h11);
      check(se, 1'b1, "headphone bit");
      wr_reg(ADDR_CTRL, 32'h1);
      hp <= 1'b1;
      repeat (6) @(posedge clk_i);
      check(se, 1'b1, "pin over bit");
      rd_chk(ADDR_STATUS, 32'h2f, "status with pin");
      hp <= 1'b0;
      repeat (6) @(posedge clk_i);
      check(se, 1'b0, "bridged");
      wr_reg(ADDR_STATUS, 32'h0);
      rd_chk(ADDR_CTRL, 32'h1, "status write ignored");
      rd_chk(4'h2, 32'h0, "unmapped read");
      rd_chk(ADDR_SETTLE, 32'(SETTLE), "settle count");
      test_done("headphone and bus");
      u_acbd_serial_host.send_word(8'h83, 8, 3);
      repeat (10) @(posedge clk_i);
      rd_chk(ADDR_VOLUME, 32'h03, "serial volume");
      u_acbd_serial_host.send_word(8'h0b, 10, 4);
      repeat (10) @(posedge clk_i);
      rd_chk(ADDR_CTRL, 32'h0b, "extra clocks");
      u_acbd_serial_host.send_word(8'h00, 5, 3);
      repeat (10) @(posedge clk_i);
      rd_chk(ADDR_CTRL, 32'h0b, "aborted word");
      test_done("serial");
      wr_reg(ADDR_CTRL, 32'h0);
      outs(6'b000011, "powered down");
      wr_reg(ADDR_CTRL, 32'h1);
      check(unity, 1'b1, "unity on wake");
      test_done("shutdown");
      complete_run;
   end
endmodule
